// [sim/ilo_exec_checker.sv]
// port assertions of the indexed offset executor
`timescale 1ns/1ps
module ilo_exec_checker
   import ilo_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic instr_ready,
   input wire logic instr_done,
   input wire logic [13:0] mem_addr,
   input wire logic mem_rd,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   wire acc = instr_valid && instr_ready;
   wire add_op = acc && instr_word[15:10] == ILO_OP_ADD;
   wire set_op = acc && instr_word[15:12] == ILO_OP_BSET;
   wire fill_op = acc && instr_word[15:9] == ILO_OP_FILL;
   sequence s_busy;
      !instr_ready [*3];
   endsequence
   sequence s_fin;
      instr_done && instr_ready;
   endsequence
   cycle_len_a: assert property (acc |=> s_busy ##1 s_fin)
      else $error("instruction length wrong");
   one_read_a: assert property (add_op || set_op |=> mem_rd ##1 !mem_rd)
      else $error("operand read missing");
   fill_wr_a: assert property (fill_op |=> !mem_rd ##2 mem_wr
      && mem_wdata == ILO_FILL) else $error("fill write wrong");
   add_w_a: assert property (add_op && !instr_word[9] |-> ##3 !mem_wr)
      else $error("add wrote memory");
   add_mem_a: assert property (add_op && instr_word[9] |-> ##3 mem_wr)
      else $error("add skipped write");
   set_bit_a: assert property (set_op |-> ##3 mem_wr && mem_wdata ==
      ($past(mem_rdata) | (8'h01 << $past(instr_word[11:9], 3))))
      else $error("bit set data wrong");
   addr_hold_a: assert property (!instr_ready && !$past(instr_ready)
      |-> $stable(mem_addr)) else $error("address moved");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   done_ready_a: assert property (instr_done |-> $past(instr_ready, 4)
      && !$past(instr_ready)) else $error("done out of place");
endmodule // ilo_exec_checker
bind ilo_exec ilo_exec_checker u_chk (.*);

// [sim/ilo_mem_model.sv]
// behavioural data memory beside the executor
`timescale 1ns/1ps
module ilo_mem_model (
   input wire logic mclk,
   input wire logic [13:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata = 8'h00
);
   logic [7:0] mem [0:16383];
   // outside a read the bus toggles
   always @(posedge mclk) begin
      if (mem_rd) mem_rdata <= mem[mem_addr];
      else mem_rdata <= ~mem_rdata;
      if (mem_wr) mem[mem_addr] <= mem_wdata;
   end
endmodule // ilo_mem_model

// [sim/tb_top.sv]
// self-checking bench of the indexed offset executor
`timescale 1ns/1ps
module tb_top;
   import ilo_pkg::*;
   logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, instr_valid = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, mem_rdata, mem_wdata;
   logic [15:0] instr_word = 16'h0000;
   logic instr_ready, instr_done, instr_unknown, mem_rd, mem_wr;
   logic [13:0] mem_addr;
   int n_fail = 0, check_count = 0, seed = 32'h7CF7;
   ilo_exec u_dut (.*);
   ilo_mem_model u_mem (.*);
   initial forever #4 mclk = ~mclk;
   task automatic chk(input logic [7:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic exec(input logic [15:0] w);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge mclk);
      instr_valid <= 1'b0;
      for (int i = 0; i < 8 && instr_done !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      chk({7'h00, instr_done}, 8'h01);
   endtask
   function automatic logic [7:0] flags(input logic [7:0] a, b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return {3'b000, s[7], a[7] == b[7] && s[7] != a[7],
         s[7:0] == 8'h00, h[4], s[8]};
   endfunction
   task automatic final_report;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      final_report;
   end
   initial begin
      logic [13:0] p, a;
      logic [7:0] k, w, v, s, e;
      logic [2:0] b;
      logic [1:0] op;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd(ILO_REG_CFG, 8'h00);
      rd(ILO_REG_STATUS, 8'h00);
      rd(4'hF, 8'h00);
      exec(16'h6810);
      chk(u_mem.mem[14'h0010], 8'hFF);
      chk({7'h00, instr_unknown}, 8'h00);
      exec(16'hF000);
      chk({7'h00, instr_unknown}, 8'h01);
      wr(ILO_REG_CFG, 8'h01);
      wr(ILO_REG_BANK, 8'h05);
      exec(16'h6960);
      chk(u_mem.mem[14'h0560], 8'hFF);
      exec(16'h6860);
      chk(u_mem.mem[14'h3F60], 8'hFF);
      $display("addressing modes done");
      for (int i = 0; i < 40; i++) begin
         p = 14'($random(seed));
         k = i == 0 ? 8'h00 : 8'($unsigned($random(seed)) % 96);
         k = i == 1 ? 8'h5F : k;
         {w, v, s} = 24'($random(seed));
         b = 3'($random(seed));
         op = i < 4 ? 2'(i) : 2'($random(seed));
         s = s & 8'h1F;
         a = p + 14'(k);
         u_mem.mem[a] = v;
         wr(ILO_REG_PTR_LO, p[7:0]);
         wr(ILO_REG_PTR_HI, {2'b00, p[13:8]});
         wr(ILO_REG_WREG, w);
         wr(ILO_REG_STATUS, s);
         exec(op[1] ? (op[0] ? {8'h68, k} : {4'h8, b, 1'b0, k})
            : {6'b001001, op[0], 1'b0, k});
         e = op[1] ? (op[0] ? 8'hFF : v | (8'h01 << b)) : w + v;
         chk(u_mem.mem[a], op == 2'd0 ? v : e);
         rd(ILO_REG_WREG, op == 2'd0 ? e : w);
         rd(ILO_REG_STATUS, op[1] ? s : flags(w, v));
         rd(ILO_REG_PTR_LO, p[7:0]);
         rd(ILO_REG_PTR_HI, {2'b00, p[13:8]});
      end
      $display("random indexed ops done");
      final_report;
   end
endmodule // tb_top

// [src/ilo_exec.sv]
// decode and execute of indexed add, bit-set and fill-ones forms
//
// How it works
// - extension on, a=0, address <=5Fh: operand is offset from pointer
// - only with a=0; addresses above 5Fh keep access-bank mapping
// - indexed add sums working register with byte at pointer plus k
// - add recognised as 0010 01d0 kkkk kkkk, d picks destination
// - d=0 result to working register, d=1 back to memory byte
// - add updates negative, overflow, carry, digit carry, zero
// - bit-set decoded as 1000 bbb0 kkkk kkkk, b picks bit 0..7
// - bit-set sets one bit, others and flags unchanged
// - fill decoded as 0110 1000 kkkk kkkk, offset 0..95
// - fill writes FFh to pointer plus offset, flags unchanged
// - each form one word, one instruction cycle of four phases
// - extension enable resets to 0; software must set it
// - no fallback to literal addressing when extension enabled
`timescale 1ns/1ps
module ilo_exec
   import ilo_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   output logic instr_ready,
   output logic instr_done,
   output logic instr_unknown,
   output logic [13:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata
);
   logic extension_enable_cfg_q;
   logic [7:0] wreg_q;
   logic [13:0] third_indirect_pointer_q;
   logic [4:0] status_q;
   logic [5:0] bank_q;
   logic [7:0] rdata_q;
   ilo_phase_t phase_q;
   ilo_dec_t dec_q;
   ilo_dec_t dec_d;
   logic ready_q;
   logic done_q;
   logic unknown_q;
   logic [13:0] mem_addr_q;
   logic mem_rd_q;
   logic mem_wr_q;
   logic [7:0] mem_wdata_q;
   logic accept;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] bit_mask;
   logic [7:0] result;

   assign accept = instr_valid && ready_q;

   // instruction decode and operand address formation
   always_comb begin
      logic [7:0] f;
      logic a;
      f = instr_word[7:0];
      a = instr_word[8];
      dec_d = '0;
      dec_d.kind = ILO_K_NONE;
      if (instr_word[15:10] == ILO_OP_ADD) begin
         dec_d.kind = ILO_K_ADD;
         dec_d.dest_file = instr_word[9];
      end else if (instr_word[15:12] == ILO_OP_BSET) begin
         dec_d.kind = ILO_K_BSET;
         dec_d.bit_sel = instr_word[11:9];
      end else if (instr_word[15:9] == ILO_OP_FILL) begin
         dec_d.kind = ILO_K_FILL;
      end
      dec_d.indexed = extension_enable_cfg_q && !a && (f <= ILO_IDX_LIMIT);
      if (dec_d.indexed) begin
         // pointer plus zero-extended offset, no literal fallback
         dec_d.addr = third_indirect_pointer_q + {6'h00, f};
      end else if (!a) begin
         // ordinary access bank: low part of bank 0 or top SFR page
         dec_d.addr = (f <= ILO_IDX_LIMIT) ? {ILO_ACC_LO_BANK, f}
                                           : {ILO_ACC_HI_BANK, f};
      end else begin
         dec_d.addr = {bank_q, f};
      end
   end

   // four-phase sequence: decode, read, process, write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_q <= ILO_DEC;
         dec_q <= '0;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         unknown_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (phase_q)
            ILO_DEC: begin
               if (accept) begin
                  dec_q <= dec_d;
                  ready_q <= 1'b0;
                  phase_q <= ILO_RD;
               end
            end
            ILO_RD: phase_q <= ILO_PROC;
            ILO_PROC: phase_q <= ILO_WR;
            ILO_WR: begin
               phase_q <= ILO_DEC;
               ready_q <= 1'b1;
               done_q <= 1'b1;
               unknown_q <= (dec_q.kind == ILO_K_NONE);
            end
            default: phase_q <= ILO_DEC;
         endcase
      end
   end

   // data path in the process phase
   always_comb begin
      sum = {1'b0, wreg_q} + {1'b0, mem_rdata};
      low_sum = {1'b0, wreg_q[3:0]} + {1'b0, mem_rdata[3:0]};
      bit_mask = 8'h01 << dec_q.bit_sel;
      case (dec_q.kind)
         ILO_K_ADD: result = sum[7:0];
         ILO_K_BSET: result = mem_rdata | bit_mask;
         ILO_K_FILL: result = ILO_FILL;
         default: result = mem_rdata;
      endcase
   end

   // data memory strobes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mem_addr_q <= 14'h0000;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_wdata_q <= 8'h00;
      end else begin
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         if (accept) begin
            mem_addr_q <= dec_d.addr;
            // fill needs no read of the old byte
            mem_rd_q <= (dec_d.kind == ILO_K_ADD)
                        || (dec_d.kind == ILO_K_BSET);
         end
         if (phase_q == ILO_PROC) begin
            mem_wdata_q <= result;
            case (dec_q.kind)
               ILO_K_ADD: mem_wr_q <= dec_q.dest_file;
               ILO_K_BSET: mem_wr_q <= 1'b1;
               ILO_K_FILL: mem_wr_q <= 1'b1;
               default: mem_wr_q <= 1'b0;
            endcase
         end
      end
   end

   // working register: bus write, add result takes priority
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wreg_q <= ILO_WREG_RST;
      end else if (phase_q == ILO_PROC && dec_q.kind == ILO_K_ADD
                   && !dec_q.dest_file) begin
         wreg_q <= sum[7:0];
      end else if (reg_wr && reg_addr == ILO_REG_WREG) begin
         wreg_q <= reg_wdata;
      end
   end

   // status flags: only the add form touches them
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_q <= ILO_STATUS_RST;
      end else if (phase_q == ILO_PROC && dec_q.kind == ILO_K_ADD) begin
         status_q[ILO_ST_C] <= sum[8];
         status_q[ILO_ST_DC] <= low_sum[4];
         status_q[ILO_ST_Z] <= (sum[7:0] == 8'h00);
         status_q[ILO_ST_OV] <= (wreg_q[7] == mem_rdata[7])
                                && (sum[7] != wreg_q[7]);
         status_q[ILO_ST_N] <= sum[7];
      end else if (reg_wr && reg_addr == ILO_REG_STATUS) begin
         status_q <= reg_wdata[4:0];
      end
   end

   // configuration, pointer and bank: software only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         extension_enable_cfg_q <= ILO_CFG_RST;
         third_indirect_pointer_q <= ILO_PTR_RST;
         bank_q <= ILO_BANK_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            ILO_REG_CFG: extension_enable_cfg_q <= reg_wdata[0];
            ILO_REG_PTR_LO: third_indirect_pointer_q[7:0] <= reg_wdata;
            ILO_REG_PTR_HI: third_indirect_pointer_q[13:8] <= reg_wdata[5:0];
            ILO_REG_BANK: bank_q <= reg_wdata[5:0];
            default: ;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ILO_REG_CFG: rdata_q <= {7'h00, extension_enable_cfg_q};
            ILO_REG_WREG: rdata_q <= wreg_q;
            ILO_REG_PTR_LO: rdata_q <= third_indirect_pointer_q[7:0];
            ILO_REG_PTR_HI: rdata_q <= {2'h0, third_indirect_pointer_q[13:8]};
            ILO_REG_STATUS: rdata_q <= {3'h0, status_q};
            ILO_REG_BANK: rdata_q <= {2'h0, bank_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;
   assign instr_ready = ready_q;
   assign instr_done = done_q;
   assign instr_unknown = unknown_q;
   assign mem_addr = mem_addr_q;
   assign mem_rd = mem_rd_q;
   assign mem_wr = mem_wr_q;
   assign mem_wdata = mem_wdata_q;
endmodule // ilo_exec

// [src/ilo_pkg.sv]
// shared constants and types of the indexed literal offset executor
package ilo_pkg;
   localparam logic [3:0] ILO_REG_CFG = 4'h0;
   localparam logic [3:0] ILO_REG_WREG = 4'h1;
   localparam logic [3:0] ILO_REG_PTR_LO = 4'h2;
   localparam logic [3:0] ILO_REG_PTR_HI = 4'h3;
   localparam logic [3:0] ILO_REG_STATUS = 4'h4;
   localparam logic [3:0] ILO_REG_BANK = 4'h5;

   localparam logic ILO_CFG_RST = 1'b0;
   localparam logic [7:0] ILO_WREG_RST = 8'h00;
   localparam logic [13:0] ILO_PTR_RST = 14'h0000;
   localparam logic [4:0] ILO_STATUS_RST = 5'h00;
   localparam logic [5:0] ILO_BANK_RST = 6'h00;

   // status bit positions
   localparam int ILO_ST_C = 0;
   localparam int ILO_ST_DC = 1;
   localparam int ILO_ST_Z = 2;
   localparam int ILO_ST_OV = 3;
   localparam int ILO_ST_N = 4;

   localparam logic [7:0] ILO_IDX_LIMIT = 8'h5F;
   localparam logic [5:0] ILO_ACC_HI_BANK = 6'h3F;
   localparam logic [5:0] ILO_ACC_LO_BANK = 6'h00;
   localparam logic [7:0] ILO_FILL = 8'hFF;

   localparam logic [5:0] ILO_OP_ADD = 6'b001001;
   localparam logic [3:0] ILO_OP_BSET = 4'b1000;
   localparam logic [6:0] ILO_OP_FILL = 7'b0110100;

   typedef enum {ILO_DEC, ILO_RD, ILO_PROC, ILO_WR} ilo_phase_t;
   typedef enum logic [1:0] {
      ILO_K_NONE,
      ILO_K_ADD,
      ILO_K_BSET,
      ILO_K_FILL
   } ilo_kind_t;

   typedef struct packed {
      ilo_kind_t kind;
      logic dest_file;
      logic [2:0] bit_sel;
      logic indexed;
      logic [13:0] addr;
   } ilo_dec_t;
endpackage
